// ---- src/interval_timer.sv ----
// Purpose: 16-bit interval timer / real-time clock time base
// Assumes: inputs synchronous to MCLK_I; control word held by software outside
// Notes: asynchronous counter mode is emulated on the system clock
//
// Functional notes
// - sixteen-bit count usable as interval timer or real-time clock base.
// - modes are internal timer, synchronised counter, unsynchronised counter.
// - prescaler ahead of counter; gate input enables time accumulation.
// - counting continues in sleep, and in idle unless idle_stop is set.
// - interrupt flag raised when count equals period value.
// - gated mode also raises interrupt on gate falling edge.
// - ext_clock_sync picks synchronised or direct external counting.
// - prescale codes 00,01,10,11 divide by 1,8,64,256.
// - source one counts external rising edges, zero counts instruction clock.
// - gated_accumulate ignored when external source selected.
// - idle_stop set halts counting during idle; clear keeps counting.
`timescale 1ns/1ps
`default_nettype none
module interval_timer #(
    parameter int WIDTH = 16
) (
    input wire logic MCLK_I,
    input wire logic RST_B_I,
    input wire interval_timer_pkg::control_word_t CONTROL_I,
    input wire logic [WIDTH-1:0] PERIOD_VALUE_I,
    input wire logic IRQ_ENABLE_I,
    input wire logic [2:0] IRQ_PRIORITY_I,
    input wire interval_timer_pkg::power_state_t POWER_I,
    input wire logic EXT_COUNT_INPUT_I,
    input wire logic GATE_I,
    input wire logic FLAG_CLEAR_I,
    output logic [WIDTH-1:0] COUNT_O,
    output logic IRQ_FLAG_O,
    output logic IRQ_O,
    output logic [2:0] IRQ_PRIORITY_O
);
    import interval_timer_pkg::*;

    // width check: prescale and compare logic sized for the documented count
    if (WIDTH != COUNT_WIDTH) begin : g_width_check
        $error("interval_timer supports WIDTH of 16 only");
    end

    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic [PRESCALE_WIDTH-1:0] prescale;
        logic ext_s1;
        logic ext_s2;
        logic ext_prev;
        logic gate_prev;
        logic flag;
        logic irq;
        logic [2:0] prio;
    } state_t;

    state_t q, d;

    // last prescaler count for each ratio
    function automatic logic [PRESCALE_WIDTH-1:0] prescale_last(input logic [1:0] sel);
        unique case (sel)
            PS_DIV1: prescale_last = PS_LAST_DIV1;
            PS_DIV8: prescale_last = PS_LAST_DIV8;
            PS_DIV64: prescale_last = PS_LAST_DIV64;
            PS_DIV256: prescale_last = PS_LAST_DIV256;
        endcase
    endfunction

    logic source_edge;
    logic gate_ok;
    logic halted;
    logic tick;
    logic gate_fall;
    logic match;

    // next-state logic for the whole block
    always_comb begin
        d = q;
        // the first stage only feeds the second; synchronised edges come from stage two
        d.ext_s1 = EXT_COUNT_INPUT_I;
        d.ext_s2 = q.ext_s1;
        // unsynchronised mode samples the raw pin: two cycles less latency
        d.ext_prev = CONTROL_I.ext_clock_sync ? q.ext_s2 : EXT_COUNT_INPUT_I;
        d.gate_prev = GATE_I;
        halted = !CONTROL_I.count_run || (CONTROL_I.idle_stop && POWER_I.idle);
        gate_ok = CONTROL_I.clock_source_select || !CONTROL_I.gated_accumulate || GATE_I;
        if (CONTROL_I.clock_source_select) begin
            source_edge = CONTROL_I.ext_clock_sync ? (q.ext_s2 && !q.ext_prev)
                                                   : (EXT_COUNT_INPUT_I && !q.ext_prev);
        end else begin
            source_edge = 1'b1; // instruction clock, every cycle
        end
        tick = 1'b0;
        // sleep does not stop the clock here, so counting goes on
        if (!halted && source_edge && gate_ok) begin
            if (q.prescale >= prescale_last(CONTROL_I.prescale_select)) begin
                d.prescale = '0;
                tick = 1'b1;
            end else begin
                d.prescale = q.prescale + 1'b1;
            end
        end
        if (!CONTROL_I.count_run) begin
            d.prescale = '0; // restart the ratio cleanly on next start
        end
        match = (q.count == PERIOD_VALUE_I);
        if (tick) begin
            d.count = match ? COUNT_RESET : q.count + 1'b1;
        end
        gate_fall = CONTROL_I.gated_accumulate && !CONTROL_I.clock_source_select
                    && q.gate_prev && !GATE_I && !halted;
        // set beats clear when both land in one cycle
        if (FLAG_CLEAR_I) begin
            d.flag = 1'b0;
        end
        if ((tick && match) || gate_fall) begin
            d.flag = 1'b1;
        end
        d.irq = d.flag && IRQ_ENABLE_I;
        d.prio = IRQ_PRIORITY_I;
    end

    // all state in one register
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            q <= '{count: COUNT_RESET, prescale: '0, ext_s1: 1'b0, ext_s2: 1'b0, ext_prev: 1'b0,
                   gate_prev: 1'b0, flag: 1'b0, irq: 1'b0, prio: 3'h0};
        end else begin
            q <= d;
        end
    end

    assign COUNT_O = q.count;
    assign IRQ_FLAG_O = q.flag;
    assign IRQ_O = q.irq;
    assign IRQ_PRIORITY_O = q.prio;

    // match on a tick wraps the count and sets the flag together
    a_match_wraps: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        (tick && match) |=> (q.count == COUNT_RESET) && q.flag)
        else $error("period match did not wrap count and set flag");

    // count holds while stopped
    a_stop_holds: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        (!CONTROL_I.count_run) |=> $stable(q.count))
        else $error("count moved while stopped");

    // idle stop freezes the count
    a_idle_freeze: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        (CONTROL_I.idle_stop && POWER_I.idle) |=> $stable(q.count))
        else $error("count moved during idle with idle_stop");

    // divide by one on internal clock advances each cycle
    a_div1_step: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        (CONTROL_I.count_run && !CONTROL_I.clock_source_select && !CONTROL_I.gated_accumulate
         && CONTROL_I.prescale_select == PS_DIV1 && !POWER_I.idle && !match)
        |=> q.count == $past(q.count) + 1'b1)
        else $error("divide by one did not step");

    // gated mode with gate low never advances
    a_gate_low: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        (!CONTROL_I.clock_source_select && CONTROL_I.gated_accumulate && !GATE_I) |=> $stable(q.count))
        else $error("count moved with gate low");

    // gate falling edge raises the flag
    a_gate_fall: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        gate_fall |=> q.flag)
        else $error("gate fall did not set flag");

    // a tick comes only at the selected terminal prescaler count
    a_prescale_cap: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        tick |-> q.prescale == prescale_last(CONTROL_I.prescale_select))
        else $error("tick at wrong prescale count");

    // external mode without an edge leaves the count alone
    a_ext_no_edge: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        (CONTROL_I.clock_source_select && !source_edge) |=> $stable(q.count))
        else $error("count moved without external edge");

    // interrupt is high only if enable was set the cycle before
    a_irq_gate: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        q.irq |-> $past(IRQ_ENABLE_I))
        else $error("irq without enable");

    // an enabled flag that nobody clears must show on the request line
    a_irq_follow: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        (q.flag && IRQ_ENABLE_I && !FLAG_CLEAR_I) |=> q.irq)
        else $error("enabled flag did not raise irq");

    // flag is sticky until software clears it
    a_flag_sticky: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        (q.flag && !FLAG_CLEAR_I) |=> q.flag)
        else $error("flag dropped without clear");

    // a clear with no competing set drops the flag
    a_flag_clear: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        (FLAG_CLEAR_I && !(tick && match) && !gate_fall) |=> !q.flag)
        else $error("flag survived a clear");

    // priority output is the input one cycle late
    a_prio_copy: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        1'b1 |=> q.prio == $past(IRQ_PRIORITY_I))
        else $error("priority not copied");

    // external source keeps counting even with gated mode set and gate low
    a_gate_ignored: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        (CONTROL_I.count_run && CONTROL_I.clock_source_select && CONTROL_I.gated_accumulate && !GATE_I
         && CONTROL_I.prescale_select == PS_DIV1 && !(CONTROL_I.idle_stop && POWER_I.idle)
         && source_edge && !match) |=> q.count == $past(q.count) + 1'b1)
        else $error("gate blocked an external count");

    // unsynchronised mode sees a pin rise in the same cycle, if the mode held still
    a_async_edge: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
        (CONTROL_I.clock_source_select && !CONTROL_I.ext_clock_sync && $stable(CONTROL_I.ext_clock_sync)
         && EXT_COUNT_INPUT_I && !$past(EXT_COUNT_INPUT_I)) |-> source_edge)
        else $error("unsynchronised edge missed");
endmodule
`default_nettype wire

// ---- src/interval_timer_pkg.sv ----
// Purpose: shared constants and carriers for the 16-bit interval timer
// Assumes: one 100 MHz clock, all inputs synchronous to it
// Notes: prescale codes and ratios live here so logic never holds bare numbers
package interval_timer_pkg;
    localparam int COUNT_WIDTH = 16;
    localparam int PRESCALE_WIDTH = 8;
    localparam int CLOCK_PERIOD_NS = 10;
    localparam logic [1:0] PS_DIV1 = 2'h0;
    localparam logic [1:0] PS_DIV8 = 2'h1;
    localparam logic [1:0] PS_DIV64 = 2'h2;
    localparam logic [1:0] PS_DIV256 = 2'h3;
    localparam logic [PRESCALE_WIDTH-1:0] PS_LAST_DIV1 = 8'h00;
    localparam logic [PRESCALE_WIDTH-1:0] PS_LAST_DIV8 = 8'h07;
    localparam logic [PRESCALE_WIDTH-1:0] PS_LAST_DIV64 = 8'h3F;
    localparam logic [PRESCALE_WIDTH-1:0] PS_LAST_DIV256 = 8'hFF;
    localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 16'h0000;
    localparam logic [COUNT_WIDTH-1:0] PERIOD_RESET = 16'hFFFF;

    // control word fields, carried together
    typedef struct packed {
        logic count_run;
        logic idle_stop;
        logic gated_accumulate;
        logic [1:0] prescale_select;
        logic ext_clock_sync;
        logic clock_source_select;
    } control_word_t;

    // processor power state seen by the timer
    typedef struct packed {
        logic idle;
        logic sleep;
    } power_state_t;
endpackage

// ---- verification/tb.sv ----
// Purpose: self-checking bench for the interval timer
// Assumes: inputs change on the falling clock edge
// Notes: expectations come from tick counts, never from the outputs
`timescale 1ns/1ps
`default_nettype none
module tb;
    import interval_timer_pkg::*;
    logic MCLK_I = 1'b0;
    logic RST_B_I = 1'b0;
    control_word_t ctl = '0;
    power_state_t pwr = '0;
    logic [15:0] per = 16'hFFFF;
    logic [15:0] lf = 16'h0044;
    logic [15:0] cnt_o;
    logic [2:0] pri = 3'h0;
    logic [2:0] pri_o;
    logic ie = 1'b0, ext = 1'b0, gate = 1'b0, clr = 1'b0, flag_o, irq_o;
    logic fell = 1'b0;
    int err_count = 0, total_checks = 0, cycles = 0, n = 0;
    always #5 MCLK_I = ~MCLK_I;
    interval_timer u_interval_timer (.MCLK_I(MCLK_I), .RST_B_I(RST_B_I), .CONTROL_I(ctl), .PERIOD_VALUE_I(per),
        .IRQ_ENABLE_I(ie), .IRQ_PRIORITY_I(pri), .POWER_I(pwr), .EXT_COUNT_INPUT_I(ext), .GATE_I(gate),
        .FLAG_CLEAR_I(clr), .COUNT_O(cnt_o), .IRQ_FLAG_O(flag_o), .IRQ_O(irq_o), .IRQ_PRIORITY_O(pri_o));
    // random source, repeatable from a fixed start
    function automatic logic [15:0] step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // source events per count step
    function automatic int ratio(input logic [1:0] ps);
        return (ps == PS_DIV1) ? 1 : (ps == PS_DIV8) ? 8 : (ps == PS_DIV64) ? 64 : 256;
    endfunction
    // running word; f holds idle_stop, gated, sync, source
    function automatic control_word_t cw(input logic [1:0] ps, input logic [3:0] f);
        return {1'h1, f[3], f[2], ps, f[1], f[0]};
    endfunction
    task automatic cyc(input int k);
        repeat (k) @(negedge MCLK_I);
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (exp !== got) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // reset between scenarios so every count starts from zero
    task automatic restart(input control_word_t c);
        RST_B_I = 1'b0;
        ctl = c;
        cyc(2);
        RST_B_I = 1'b1;
    endtask
    task automatic complete_run;
        if (err_count == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // hang guard, far above the roughly 1200 cycles needed
    always @(posedge MCLK_I) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            complete_run();
        end
    end
    initial begin
        cyc(16);
        RST_B_I = 1'b1;
        // let two edges pass so the checks see the released state
        cyc(2);
        chk("count after reset", 16'h0, cnt_o);
        chk("flag after reset", 16'h0, 16'(flag_o));
        chk("irq after reset", 16'h0, 16'(irq_o));
        // random short periods, enables and priorities
        for (int r = 0; r < 4; r++) begin
            lf = step(lf);
            per = {12'h0, lf[3:0]} + 16'h2;
            ie = lf[4];
            pri = lf[7:5];
            restart(cw(PS_DIV1, 4'h0));
            cyc(int'(per));
            chk("count at period", per, cnt_o);
            chk("flag before match", 16'h0, 16'(flag_o));
            cyc(1);
            chk("count wrapped", 16'h0, cnt_o);
            chk("flag on match", 16'h1, 16'(flag_o));
            chk("irq with flag", 16'(ie), 16'(irq_o));
            cyc(1);
            chk("irq", 16'(ie), 16'(irq_o));
            chk("priority", 16'(pri), 16'(pri_o));
        end
        // each ratio checked just before and at the third step
        per = 16'hFFFF;
        for (int p = 0; p < 4; p++) begin
            restart(cw(2'(p), 4'h0));
            cyc(3 * ratio(2'(p)) - 1);
            chk("count before step", 16'h2, cnt_o);
            cyc(1);
            chk("prescaled count", 16'h3, cnt_o);
        end
        // idle with stop halts; without stop, idle and sleep keep counting
        pwr = 2'h3;
        restart(cw(PS_DIV1, 4'h8));
        cyc(5);
        chk("idle stopped", 16'h0, cnt_o);
        restart(cw(PS_DIV1, 4'h0));
        cyc(5);
        chk("idle running", 16'h5, cnt_o);
        // random gate pattern, count only the high cycles
        pwr = 2'h0;
        restart(cw(PS_DIV1, 4'h4));
        for (int i = 0; i < 40; i++) begin
            lf = step(lf);
            fell = fell | (gate & ~lf[0]); // a high then low pair sets the flag
            gate = lf[0];
            n += int'(gate);
            cyc(1);
        end
        chk("gated count", 16'(n), cnt_o);
        chk("flag before clear", 16'(fell), 16'(flag_o));
        gate = 1'b1;
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        cyc(1);
        chk("flag cleared", 16'h0, 16'(flag_o));
        gate = 1'b0;
        cyc(2);
        chk("gate fall flag", 16'h1, 16'(flag_o));
        // external edges, gate low and gated set to show it is ignored
        for (int s = 0; s < 2; s++) begin
            restart(cw(PS_DIV1, {2'h1, s[0], 1'h1}));
            for (int k = 0; k < 5; k++) begin
                ext = 1'b1;
                cyc(2);
                ext = 1'b0;
                cyc(2);
            end
            cyc(4);
            chk("external edges", 16'h5, cnt_o);
        end
        complete_run();
    end
endmodule
`default_nettype wire
